// >>> hdl/cwf_pkg.sv
// package: register map, field layouts and constants of the can wake filter
package cwf_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] TIMING_OFF = 8'h04;
    localparam logic [7:0] FAST_OFF = 8'h08;
    localparam logic [7:0] REF_ID_OFF = 8'h0c;
    localparam logic [7:0] MASK_OFF = 8'h10;
    localparam logic [7:0] TMO_OFF = 8'h14;
    localparam logic [7:0] STAT_OFF = 8'h18;
    localparam logic [7:0] IRQ_EN_OFF = 8'h1c;
    localparam logic [7:0] STATE_OFF = 8'h20;
    // control field positions
    localparam int CTRL_ACTIVE = 0;
    localparam int CTRL_TALK = 1;
    localparam int CTRL_FD_EN = 2;
    localparam int CTRL_EXT = 3;
    localparam int CTRL_MODE_LO = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // identifier widths
    localparam int STD_ID_W = 11;
    localparam int EXT_ID_W = 29;
    localparam logic [28:0] STD_ID_MASK = 29'h0000_07ff;
    // status bit positions
    localparam int ST_TIMEOUT = 0;
    localparam int ST_WAKE = 1;
    localparam int ST_W = 2;
    // timeout default, in milliseconds, and clock rate
    localparam int CLK_HZ = 20_000_000;
    localparam int TMO_DEF_MS = 1000;
    localparam logic [31:0] TMO_DEF_CYC = 32'(TMO_DEF_MS * (CLK_HZ / 1000));
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // wake modes
    typedef enum logic [1:0] {
        CWF_WAKE_OFF = 2'b00,
        CWF_WAKE_ON = 2'b01,
        CWF_WAKE_LOSSLESS = 2'b10,
        CWF_WAKE_KEEP = 2'b11
    } cwf_mode_e;
    // power state
    typedef enum logic [1:0] {
        CWF_ASLEEP = 2'b00,
        CWF_AWAKE = 2'b01,
        CWF_IDLE = 2'b10
    } cwf_pwr_e;
    // received frame identifier
    typedef struct packed {
        logic valid;
        logic ext;
        logic [28:0] id;
    } cwf_frame_s;
    // bit timing settings
    typedef struct packed {
        logic [15:0] rate_div;
        logic [7:0] sample_pt;
        logic [7:0] sjw;
    } cwf_timing_s;
endpackage

// >>> hdl/cwf_wake_filter.sv
// module: can wake-up identifier filter, timeout and channel configuration
// ----------------------------------------------------------------------------
// Summary of operation
// - only id bits whose mask bit is one are compared, the rest are ignored.
// - a wake needs every masked id bit equal to the reference, payload ignored.
// - a mask of zero makes every received frame of the configured format a wake.
// - reference and mask may be standard (11-bit, bits 0..10) or extended.
// - a waking channel idle for the timeout is inactive and may allow shutdown.
// - a timeout logs an entry and raises an alert that stays until acknowledged.
// - disabled wake mode never starts the logger from frames.
// - enabled mode starts on a qualifying frame, early frames may be lost.
// - lossless mode starts on a qualifying frame and keeps every frame.
// - keep-awake starts with ignition and stops only when all wake sources drop.
// - with communicate off the channel stays silent and never drives the bus.
// - the nominal bit rate is selectable and must match all other nodes.
// - only fd channels with fd enabled use a separate fast data rate.
// - on fd channels the sample point and jump width serve both phases.
// - a deactivated channel passes no signal to storage or tracing.
// ----------------------------------------------------------------------------
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module cwf_wake_filter #(
    parameter bit FD_CAPABLE = 1'b1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // can receive side
    input wire cwf_pkg::cwf_frame_s RX_FRAME,
    input wire logic BUS_ACTIVITY,
    // power sources
    input wire logic IGNITION,
    input wire logic OTHER_WAKE,
    // channel outputs
    output logic WAKE_REQ,
    output logic SHUTDOWN_OK,
    output logic RX_BUFFER_ON,
    output logic TX_ENABLE,
    output logic STORE_ENABLE,
    output logic LOG_ENTRY,
    output logic [15:0] NOM_RATE_DIV,
    output logic [15:0] DATA_RATE_DIV,
    output logic [7:0] SAMPLE_PT,
    output logic [7:0] SJW,
    output logic IRQ
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [31:0] ctrl_q;
    cwf_pkg::cwf_timing_s timing_q;
    logic [15:0] fast_q;
    logic [28:0] ref_id_q;
    logic [28:0] mask_q;
    logic [31:0] tmo_q;
    logic [cwf_pkg::ST_W-1:0] stat_q;
    logic [cwf_pkg::ST_W-1:0] irq_en_q;
    logic [31:0] idle_cnt_q;
    cwf_pkg::cwf_pwr_e pwr_q;
    cwf_pkg::cwf_mode_e mode;
    logic active;
    logic ext_fmt;
    logic fd_on;
    logic [28:0] fmt_mask;
    logic id_hit;
    logic frame_wake;
    logic any_wake_source;
    logic tmo_hit;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_d;
    logic addr_ok;

    // control fields decoded from the control register
    assign mode = cwf_pkg::cwf_mode_e'(ctrl_q[cwf_pkg::CTRL_MODE_LO +: 2]);
    assign active = ctrl_q[cwf_pkg::CTRL_ACTIVE];
    assign ext_fmt = ctrl_q[cwf_pkg::CTRL_EXT];
    assign fd_on = FD_CAPABLE && ctrl_q[cwf_pkg::CTRL_FD_EN];
    assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
    assign rd_en = PSEL && !PENABLE && !PWRITE;

    // ------------------------------------------------------------------------
    // identifier filter
    // ------------------------------------------------------------------------
    // standard format keeps only bits 0..10, extended all 29
    assign fmt_mask = ext_fmt ? {29{1'b1}} : cwf_pkg::STD_ID_MASK;
    // masked compare, zero mask bits are don't-care
    assign id_hit = (((RX_FRAME.id ^ ref_id_q) & mask_q & fmt_mask) == 29'h0);
    // a qualifying frame of the configured format wakes
    assign frame_wake = active && RX_FRAME.valid && (RX_FRAME.ext == ext_fmt) && id_hit;
    assign any_wake_source = IGNITION || OTHER_WAKE;
    assign tmo_hit = (pwr_q == cwf_pkg::CWF_AWAKE) && (idle_cnt_q >= tmo_q) && active;

    // ------------------------------------------------------------------------
    // power state
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pwr_q <= cwf_pkg::CWF_ASLEEP;
        end else begin
            case (pwr_q)
                cwf_pkg::CWF_ASLEEP: begin
                    case (mode)
                        cwf_pkg::CWF_WAKE_OFF: pwr_q <= cwf_pkg::CWF_ASLEEP;
                        cwf_pkg::CWF_WAKE_KEEP: begin
                            if (IGNITION) begin
                                pwr_q <= cwf_pkg::CWF_AWAKE;
                            end
                        end
                        default: begin
                            if (frame_wake) begin
                                pwr_q <= cwf_pkg::CWF_AWAKE;
                            end
                        end
                    endcase
                end
                cwf_pkg::CWF_AWAKE: begin
                    if (mode == cwf_pkg::CWF_WAKE_KEEP) begin
                        if (!any_wake_source && tmo_hit) begin
                            pwr_q <= cwf_pkg::CWF_IDLE;
                        end
                    end else if (tmo_hit) begin
                        pwr_q <= cwf_pkg::CWF_IDLE;
                    end
                end
                cwf_pkg::CWF_IDLE: begin
                    if (frame_wake && mode != cwf_pkg::CWF_WAKE_OFF) begin
                        pwr_q <= cwf_pkg::CWF_AWAKE;
                    end else if (mode == cwf_pkg::CWF_WAKE_KEEP && any_wake_source) begin
                        pwr_q <= cwf_pkg::CWF_AWAKE;
                    end else begin
                        pwr_q <= cwf_pkg::CWF_ASLEEP;
                    end
                end
                default: pwr_q <= cwf_pkg::CWF_ASLEEP;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // inactivity counter
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            idle_cnt_q <= cwf_pkg::ZERO32;
        end else if (BUS_ACTIVITY || pwr_q != cwf_pkg::CWF_AWAKE) begin
            idle_cnt_q <= cwf_pkg::ZERO32;
        // saturates so a long idle spell never wraps below the timeout
        end else if (idle_cnt_q != {32{1'b1}}) begin
            idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------------
    // channel outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WAKE_REQ <= 1'b0;
            SHUTDOWN_OK <= 1'b1;
            RX_BUFFER_ON <= 1'b0;
            TX_ENABLE <= 1'b0;
            STORE_ENABLE <= 1'b0;
            LOG_ENTRY <= 1'b0;
        end else begin
            WAKE_REQ <= (pwr_q == cwf_pkg::CWF_AWAKE);
            SHUTDOWN_OK <= (pwr_q != cwf_pkg::CWF_AWAKE);
            // lossless mode buffers frames even while asleep
            RX_BUFFER_ON <= active && ((pwr_q == cwf_pkg::CWF_AWAKE)
                || mode == cwf_pkg::CWF_WAKE_LOSSLESS);
            TX_ENABLE <= active && ctrl_q[cwf_pkg::CTRL_TALK];
            STORE_ENABLE <= active && (pwr_q == cwf_pkg::CWF_AWAKE);
            LOG_ENTRY <= tmo_hit;
        end
    end

    // ------------------------------------------------------------------------
    // bit timing outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            NOM_RATE_DIV <= 16'h0000;
            DATA_RATE_DIV <= 16'h0000;
            SAMPLE_PT <= 8'h00;
            SJW <= 8'h00;
        end else begin
            NOM_RATE_DIV <= timing_q.rate_div;
            // without fd the data phase reuses the nominal divider
            DATA_RATE_DIV <= fd_on ? fast_q : timing_q.rate_div;
            SAMPLE_PT <= timing_q.sample_pt;
            SJW <= timing_q.sjw;
        end
    end

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ctrl_q <= cwf_pkg::CTRL_RST;
            timing_q <= '0;
            fast_q <= 16'h0000;
            ref_id_q <= 29'h0;
            mask_q <= 29'h0;
            tmo_q <= cwf_pkg::TMO_DEF_CYC;
            irq_en_q <= '0;
        end else if (wr_en) begin
            case (PADDR)
                cwf_pkg::CTRL_OFF: ctrl_q <= {26'h0, PWDATA[5:0]};
                cwf_pkg::TIMING_OFF: timing_q <= PWDATA;
                cwf_pkg::FAST_OFF: fast_q <= PWDATA[15:0];
                cwf_pkg::REF_ID_OFF: ref_id_q <= PWDATA[28:0];
                cwf_pkg::MASK_OFF: mask_q <= PWDATA[28:0];
                cwf_pkg::TMO_OFF: tmo_q <= PWDATA;
                cwf_pkg::IRQ_EN_OFF: irq_en_q <= PWDATA[cwf_pkg::ST_W-1:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // sticky status, set wins over write-one-to-clear
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            stat_q <= '0;
        end else begin
            for (int i = 0; i < cwf_pkg::ST_W; i++) begin
                if (wr_en && PADDR == cwf_pkg::STAT_OFF && PWDATA[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
            if (tmo_hit) begin
                stat_q[cwf_pkg::ST_TIMEOUT] <= 1'b1;
            end
            if (frame_wake && mode != cwf_pkg::CWF_WAKE_OFF) begin
                stat_q[cwf_pkg::ST_WAKE] <= 1'b1;
            end
        end
    end

    // interrupt level, one cycle behind the status bits
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat_q & irq_en_q);
        end
    end

    // ------------------------------------------------------------------------
    // apb read path, no wait state
    // ------------------------------------------------------------------------
    always_comb begin
        addr_ok = 1'b1;
        case (PADDR)
            cwf_pkg::CTRL_OFF: rd_d = ctrl_q;
            cwf_pkg::TIMING_OFF: rd_d = timing_q;
            cwf_pkg::FAST_OFF: rd_d = {16'h0, fast_q};
            cwf_pkg::REF_ID_OFF: rd_d = {3'h0, ref_id_q};
            cwf_pkg::MASK_OFF: rd_d = {3'h0, mask_q};
            cwf_pkg::TMO_OFF: rd_d = tmo_q;
            cwf_pkg::STAT_OFF: rd_d = {30'h0, stat_q};
            cwf_pkg::IRQ_EN_OFF: rd_d = {30'h0, irq_en_q};
            cwf_pkg::STATE_OFF: rd_d = {30'h0, pwr_q};
            default: begin
                rd_d = cwf_pkg::ZERO32;
                addr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PRDATA <= cwf_pkg::ZERO32;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !addr_ok;
            if (rd_en) begin
                PRDATA <= rd_d;
            end
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    sequence s_idle_run;
        tmo_hit && mode != cwf_pkg::CWF_WAKE_KEEP;
    endsequence

    a_mask_zero_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
        (active && RX_FRAME.valid && RX_FRAME.ext == ext_fmt && mask_q == 29'h0)
        |-> frame_wake)
        else $error("zero mask did not wake");
    a_masked_mismatch: assert property (@(posedge CLK) disable iff (SYS_RST)
        (((RX_FRAME.id ^ ref_id_q) & mask_q & fmt_mask) != 29'h0) |-> !frame_wake)
        else $error("masked id mismatch woke");
    a_std_upper_bits: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!ext_fmt && ((RX_FRAME.id ^ ref_id_q) & mask_q & cwf_pkg::STD_ID_MASK) == 29'h0)
        |-> id_hit)
        else $error("standard compare used upper bits");
    a_off_never_wakes: assert property (@(posedge CLK) disable iff (SYS_RST)
        (pwr_q == cwf_pkg::CWF_ASLEEP && mode == cwf_pkg::CWF_WAKE_OFF)
        |=> pwr_q == cwf_pkg::CWF_ASLEEP)
        else $error("disabled mode woke");
    a_frame_wakes: assert property (@(posedge CLK) disable iff (SYS_RST)
        (pwr_q == cwf_pkg::CWF_ASLEEP && frame_wake && mode == cwf_pkg::CWF_WAKE_ON)
        |=> ##1 WAKE_REQ)
        else $error("qualifying frame did not wake");
    a_lossless_buf: assert property (@(posedge CLK) disable iff (SYS_RST)
        (active && mode == cwf_pkg::CWF_WAKE_LOSSLESS && $stable(ctrl_q)) |=> RX_BUFFER_ON)
        else $error("lossless mode not buffering");
    a_keep_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        (pwr_q == cwf_pkg::CWF_AWAKE && mode == cwf_pkg::CWF_WAKE_KEEP && any_wake_source)
        |=> pwr_q == cwf_pkg::CWF_AWAKE)
        else $error("keep awake dropped with source present");
    a_timeout_sleep: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_idle_run |=> pwr_q == cwf_pkg::CWF_IDLE ##1 SHUTDOWN_OK)
        else $error("timeout did not allow shutdown");
    a_alert_pend: assert property (@(posedge CLK) disable iff (SYS_RST)
        tmo_hit |=> stat_q[cwf_pkg::ST_TIMEOUT] && LOG_ENTRY)
        else $error("timeout alert not raised");
    a_silent_tx: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ctrl_q[cwf_pkg::CTRL_TALK] && $stable(ctrl_q) |=> !TX_ENABLE)
        else $error("silent channel enabled transmit");
    a_fast_rate: assert property (@(posedge CLK) disable iff (SYS_RST)
        !fd_on && $stable(timing_q) && $stable(ctrl_q) |=> DATA_RATE_DIV == NOM_RATE_DIV)
        else $error("fast rate used without fd");
    a_inactive_store: assert property (@(posedge CLK) disable iff (SYS_RST)
        !active |=> !STORE_ENABLE && !TX_ENABLE)
        else $error("inactive channel stored");

    // keep-awake start from ignition
    sequence s_keep_start;
        pwr_q == cwf_pkg::CWF_ASLEEP && mode == cwf_pkg::CWF_WAKE_KEEP && IGNITION;
    endsequence

    a_keep_start: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_keep_start |=> pwr_q == cwf_pkg::CWF_AWAKE ##1 WAKE_REQ)
        else $error("ignition did not wake");

    a_awake_no_shut: assert property (@(posedge CLK) disable iff (SYS_RST)
        pwr_q == cwf_pkg::CWF_AWAKE |=> !SHUTDOWN_OK)
        else $error("shutdown allowed while awake");

    a_alert_held: assert property (@(posedge CLK) disable iff (SYS_RST)
        stat_q[cwf_pkg::ST_TIMEOUT] && !(wr_en && PADDR == cwf_pkg::STAT_OFF)
        |=> stat_q[cwf_pkg::ST_TIMEOUT])
        else $error("timeout alert lost before acknowledge");

    a_ext_compare: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ext_fmt && ((RX_FRAME.id ^ ref_id_q) & mask_q) != 29'h0) |-> !id_hit)
        else $error("extended compare ignored a masked bit");

    a_timing_copy: assert property (@(posedge CLK) disable iff (SYS_RST)
        1'b1 |=> NOM_RATE_DIV == $past(timing_q.rate_div) && SJW == $past(timing_q.sjw))
        else $error("bit timing not passed on");
endmodule // cwf_wake_filter

// >>> tb/cwf_can_node.sv
// partner model: another node on the shared can bus handing frames to the channel
`timescale 1ns/1ps
module cwf_can_node (
    // clock
    input wire logic clk,
    // receive side of the channel
    output cwf_pkg::cwf_frame_s rx_frame,
    output logic bus_activity
);
    // --------------------------------------------------------------------
    // quiet bus at time zero
    // --------------------------------------------------------------------
    initial begin
        rx_frame = '0;
        bus_activity = 1'b0;
    end

    // one frame at the shared nominal rate, seen as a single valid cycle
    task automatic send(input logic ext, input logic [28:0] id);
        @(posedge clk);
        rx_frame <= '{valid: 1'b1, ext: ext, id: id};
        bus_activity <= 1'b1;
        @(posedge clk);
        rx_frame <= '{valid: 1'b0, ext: ext, id: ~id}; // released id lines flipped
        bus_activity <= 1'b0;
    endtask
endmodule // cwf_can_node

// >>> tb/can_wake_id_filter_tb.sv
// testbench: wake filter channel driven over apb with a bus node model
`timescale 1ns/1ps
module can_wake_id_filter_tb;
    // --------------------------------------------------------------------
    // signals
    // --------------------------------------------------------------------
    logic clk, sys_rst, psel, penable, pwrite, ignition, other_wake, se;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, wake_req, shutdown_ok, rx_buffer_on, tx_enable;
    logic store_enable, log_entry, irq, bus_activity;
    logic [15:0] nom_rate_div, data_rate_div;
    logic [7:0] sample_pt, sjw;
    cwf_pkg::cwf_frame_s rx_frame;
    int err_total, checks, cycles;

    // design and far-side node
    cwf_wake_filter i_cwf_wake_filter (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_FRAME(rx_frame),
        .BUS_ACTIVITY(bus_activity), .IGNITION(ignition), .OTHER_WAKE(other_wake),
        .WAKE_REQ(wake_req), .SHUTDOWN_OK(shutdown_ok), .RX_BUFFER_ON(rx_buffer_on),
        .TX_ENABLE(tx_enable), .STORE_ENABLE(store_enable), .LOG_ENTRY(log_entry),
        .NOM_RATE_DIV(nom_rate_div), .DATA_RATE_DIV(data_rate_div),
        .SAMPLE_PT(sample_pt), .SJW(sjw), .IRQ(irq));
    cwf_can_node i_cwf_can_node (.clk(clk), .rx_frame(rx_frame),
        .bus_activity(bus_activity));

    // 20 mhz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("ready_wait", 32'(n), 32'h1);
    endtask

    function automatic logic [31:0] ctrl(input cwf_pkg::cwf_mode_e m, input logic ext,
        input logic talk, input logic fd, input logic act);
        ctrl = (32'(m) << cwf_pkg::CTRL_MODE_LO) | (32'(ext) << cwf_pkg::CTRL_EXT)
            | (32'(talk) << cwf_pkg::CTRL_TALK) | (32'(fd) << cwf_pkg::CTRL_FD_EN) | 32'(act);
    endfunction

    task automatic wait_sleep();
        int n;
        n = 0;
        while (wake_req !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("asleep", 32'(wake_req), 32'h0);
    endtask

    task automatic frame_wake(input logic ext, input logic [28:0] id, input logic exp);
        i_cwf_can_node.send(ext, id);
        cyc(4);
        chk("wake", 32'(wake_req), 32'(exp));
    endtask

    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, cwf_pkg::CTRL_OFF, 32'h0);
        chk("ctrl", rd, cwf_pkg::CTRL_RST);
        apb(1'b0, cwf_pkg::TMO_OFF, 32'h0);
        chk("tmo", rd, cwf_pkg::TMO_DEF_CYC);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped", {rd[30:0], se}, 32'h1);
        chk("shutdown", 32'(shutdown_ok), 32'h1);
        apb(1'b1, cwf_pkg::TMO_OFF, 32'h14);
        apb(1'b1, cwf_pkg::IRQ_EN_OFF, 32'h1);
        $display("test reset finished");
    endtask

    task automatic t_std();
        logic [28:0] ids [9] = '{29'd277, 29'd87, 29'd1044, 29'd247, 29'd150, 29'd20,
            29'd21, 29'h814, 29'd281};
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b0, 1'b0, 1'b0, 1'b1));
        apb(1'b1, cwf_pkg::REF_ID_OFF, 32'h16);
        apb(1'b1, cwf_pkg::MASK_OFF, 32'h1c);
        chk("buffer_asleep", 32'(rx_buffer_on), 32'h0);
        foreach (ids[i]) begin
            frame_wake(1'b0, ids[i], i < 8);
            chk("store", 32'(store_enable), 32'(i < 8));
            wait_sleep();
        end
        apb(1'b1, cwf_pkg::MASK_OFF, 32'h0);
        frame_wake(1'b0, 29'd281, 1'b1);
        wait_sleep();
        $display("test standard filter finished");
    endtask

    task automatic t_ext();
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b1, 1'b0, 1'b0, 1'b1));
        apb(1'b1, cwf_pkg::REF_ID_OFF, 32'h1555_0016);
        apb(1'b1, cwf_pkg::MASK_OFF, 32'h1fff_0000);
        frame_wake(1'b1, 29'h0555_0016, 1'b0);
        frame_wake(1'b1, 29'h1555_ffff, 1'b1);
        wait_sleep();
        $display("test extended filter finished");
    endtask

    task automatic t_timeout();
        int n;
        n = 0;
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b0, 1'b0, 1'b0, 1'b1));
        apb(1'b1, cwf_pkg::MASK_OFF, 32'h0);
        apb(1'b1, cwf_pkg::STAT_OFF, 32'h3);
        repeat (6) frame_wake(1'b0, 29'd5, 1'b1);
        chk("no_shutdown", 32'(shutdown_ok), 32'h0);
        apb(1'b0, cwf_pkg::STATE_OFF, 32'h0);
        chk("state", rd, 32'(cwf_pkg::CWF_AWAKE));
        while (log_entry !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("log", 32'(log_entry), 32'h1);
        wait_sleep();
        chk("shutdown", 32'(shutdown_ok), 32'h1);
        apb(1'b0, cwf_pkg::STAT_OFF, 32'h0);
        chk("status", 32'(rd[cwf_pkg::ST_TIMEOUT]), 32'h1);
        chk("irq_pending", 32'(irq), 32'h1);
        apb(1'b1, cwf_pkg::STAT_OFF, 32'h3);
        cyc(2);
        chk("irq_clear", 32'(irq), 32'h0);
        apb(1'b1, cwf_pkg::IRQ_EN_OFF, 32'h0);
        frame_wake(1'b0, 29'd6, 1'b1);
        wait_sleep();
        cyc(2);
        chk("irq_masked", 32'(irq), 32'h0);
        apb(1'b1, cwf_pkg::STAT_OFF, 32'h3);
        $display("test timeout finished");
    endtask

    task automatic t_modes();
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_OFF, 1'b0, 1'b0, 1'b0, 1'b1));
        frame_wake(1'b0, 29'd9, 1'b0);
        chk("buffer_off", 32'(rx_buffer_on), 32'h0);
        apb(1'b1, cwf_pkg::CTRL_OFF,
            ctrl(cwf_pkg::CWF_WAKE_LOSSLESS, 1'b0, 1'b0, 1'b0, 1'b1));
        cyc(2);
        chk("buffer_lossless", 32'(rx_buffer_on), 32'h1);
        frame_wake(1'b0, 29'd9, 1'b1);
        wait_sleep();
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_KEEP, 1'b0, 1'b0, 1'b0, 1'b1));
        ignition <= 1'b1;
        cyc(4);
        chk("keep_ign", 32'(wake_req), 32'h1);
        cyc(40);
        other_wake <= 1'b1;
        ignition <= 1'b0;
        cyc(40);
        chk("keep_other", 32'(wake_req), 32'h1);
        other_wake <= 1'b0;
        wait_sleep();
        $display("test modes finished");
    endtask

    task automatic t_config();
        apb(1'b1, cwf_pkg::TIMING_OFF, 32'h0123_4a05);
        apb(1'b1, cwf_pkg::FAST_OFF, 32'h0000_0007);
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b0, 1'b1, 1'b1, 1'b1));
        cyc(2);
        chk("nom_div", 32'(nom_rate_div), 32'h0123);
        chk("sample", 32'(sample_pt), 32'h4a);
        chk("sjw", 32'(sjw), 32'h05);
        chk("data_div", 32'(data_rate_div), 32'h0007);
        chk("tx_talk", 32'(tx_enable), 32'h1);
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b0, 1'b0, 1'b1, 1'b1));
        cyc(2);
        chk("tx_silent", 32'(tx_enable), 32'h0);
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b0, 1'b1, 1'b1, 1'b0));
        i_cwf_can_node.send(1'b0, 29'd3);
        cyc(4);
        chk("store_off", 32'(store_enable), 32'h0);
        chk("tx_off", 32'(tx_enable), 32'h0);
        chk("buffer_inactive", 32'(rx_buffer_on), 32'h0);
        apb(1'b1, cwf_pkg::CTRL_OFF, ctrl(cwf_pkg::CWF_WAKE_ON, 1'b0, 1'b0, 1'b0, 1'b1));
        cyc(2);
        chk("data_nominal", 32'(data_rate_div), 32'h0123);
        wait_sleep();
        $display("test configuration finished");
    endtask

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        {sys_rst, psel, penable, pwrite, ignition, other_wake} = 6'b100000;
        paddr = 8'h00;
        pwdata = 32'h0;
        {err_total, checks, cycles} = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_std();
        t_ext();
        t_timeout();
        t_modes();
        t_config();
        complete_run();
    end
endmodule // can_wake_id_filter_tb
